// *** logic/sfs_defines.svh ***
// constants of the synchronous flow-through sram port
`ifndef SFS_DEFINES_SVH
`define SFS_DEFINES_SVH
`define SFS_ADDR_W 19
`define SFS_LANES 4
`define SFS_BYTE_W 8
`define SFS_MEM_DEPTH 524288
`define SFS_SYNC_W 3
`define SFS_BURST_W 2
`define SFS_CNT_RST 2'h0
`endif

// *** logic/sfs_pkg.sv ***
// types of the synchronous flow-through sram port
`include "sfs_defines.svh"
package sfs_pkg;
    typedef logic [`SFS_ADDR_W-1:0] sfs_addr_t;
    typedef logic [`SFS_LANES-1:0] sfs_lanes_t;
    typedef logic [`SFS_BURST_W-1:0] sfs_burst_t;
    typedef struct packed {
        logic [`SFS_LANES-1:0] parity_data_bits;
        logic [`SFS_LANES*`SFS_BYTE_W-1:0] data;
    } sfs_word_t;
    typedef enum logic [1:0] {SFS_IDLE, SFS_READ, SFS_WRITE} sfs_op_t;
    typedef struct packed {
        sfs_op_t op;
        sfs_addr_t addr;
        sfs_burst_t burst_start;
        sfs_burst_t burst_cnt;
        logic wr_pend;
        sfs_addr_t wr_addr;
        sfs_lanes_t wr_lanes;
        logic drive;
        sfs_word_t rdata;
        logic [`SFS_SYNC_W-1:0] sleep_sync;
        logic sleep;
        logic low_power;
    } sfs_state_t;
endpackage

// *** logic/sfs_sram_port.sv ***
// device side of a synchronous flow-through burst sram port
// Operation
// - Address, selects, write enable, lane selects and load/advance are registered on the rising edge.
// - With the clock qualifier high the edge is ignored and state and outputs hold, except that the sleep synchronizer and sleep still act.
// - Writes complete internally with no extra strobes or wait cycles.
// - The device is selected only when select a is low, select b high and select c low.
// - Output enable gates the data drivers without reference to the clock.
// - The data drivers are off during the data phase of a write.
// - Reads and writes follow back to back in any order with no dead cycles.
// - Inputs are registered and read data follows the capturing edge within the same cycle.
// - Driver control is internal so the bus works with output enable held active.
// - Bursts step through the two low address bits in linear or interleaved order.
// - Sleep or deselection puts the device into its low-power state.
`timescale 1ns/1ps
`include "sfs_defines.svh"
module sfs_sram_port
    import sfs_pkg::*;
#(
    parameter int MEM_DEPTH = `SFS_MEM_DEPTH
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic clock_qualify_n_i,
    input wire logic chip_select_a_n_i,
    input wire logic chip_select_b_i,
    input wire logic chip_select_c_n_i,
    input wire logic write_enable_n_i,
    input wire sfs_lanes_t byte_lane_write_n_i,
    input wire logic load_or_advance_i,
    // bits 1:0 are burst_addr_bit1 and burst_addr_bit0
    input wire sfs_addr_t address_i,
    // high selects interleaved order
    input wire logic burst_order_i,
    input wire logic output_enable_n_i,
    input wire logic sleep_request_i,
    input wire sfs_word_t dq_i,
    output sfs_word_t dq_o,
    output logic dq_oe_o,
    output logic low_power_o
);
    localparam int IDX_W = (MEM_DEPTH > 1) ? $clog2(MEM_DEPTH) : 1;

    // contents are not reset: a real array has no reset either
    sfs_word_t mem [MEM_DEPTH];

    sfs_state_t st_q;
    sfs_state_t st_d;

    logic ce;
    logic sel;
    logic mem_we;
    sfs_word_t wr_old;
    sfs_word_t wr_merged;
    sfs_burst_t cnt_nx;
    logic [IDX_W-1:0] wr_idx;
    logic [IDX_W-1:0] rd_idx;

    assign ce = !clock_qualify_n_i;
    assign sel = !chip_select_a_n_i && chip_select_b_i && !chip_select_c_n_i;
    // write data lands one enabled edge after its command
    assign mem_we = ce && st_q.wr_pend;
    assign wr_idx = st_q.wr_addr[IDX_W-1:0];
    assign wr_old = mem[wr_idx];
    assign cnt_nx = st_q.burst_cnt + 2'h1;

    genvar gl;
    generate
        for (gl = 0; gl < `SFS_LANES; gl++) begin : g_lane
            // only the lanes selected with the command are updated
            assign wr_merged.data[gl*`SFS_BYTE_W +: `SFS_BYTE_W] = st_q.wr_lanes[gl] ?
                dq_i.data[gl*`SFS_BYTE_W +: `SFS_BYTE_W] :
                wr_old.data[gl*`SFS_BYTE_W +: `SFS_BYTE_W];
            assign wr_merged.parity_data_bits[gl] = st_q.wr_lanes[gl] ?
                dq_i.parity_data_bits[gl] : wr_old.parity_data_bits[gl];
        end
    endgenerate

    always_ff @(posedge sys_clk_i) begin
        if (mem_we) begin
            mem[wr_idx] <= wr_merged;
        end
    end

    always_comb begin
        st_d = st_q;
        rd_idx = '0;
        // sleep pin is asynchronous: act once the last two stages agree
        st_d.sleep_sync = {st_q.sleep_sync[`SFS_SYNC_W-2:0], sleep_request_i};
        if (st_q.sleep_sync[2] == st_q.sleep_sync[1]) begin
            st_d.sleep = st_q.sleep_sync[2];
        end
        if (ce) begin
            st_d.wr_pend = 1'b0;
            if (!load_or_advance_i) begin
                if (sel && !st_q.sleep) begin
                    st_d.op = write_enable_n_i ? SFS_READ : SFS_WRITE;
                    st_d.addr = address_i;
                    st_d.burst_start = address_i[1:0];
                    st_d.burst_cnt = `SFS_CNT_RST;
                end else begin
                    st_d.op = SFS_IDLE;
                end
            end else if (st_q.op != SFS_IDLE) begin
                st_d.burst_cnt = cnt_nx;
                if (burst_order_i) begin
                    st_d.addr[1:0] = st_q.burst_start ^ cnt_nx;
                end else begin
                    st_d.addr[1:0] = st_q.burst_start + cnt_nx;
                end
            end
            rd_idx = st_d.addr[IDX_W-1:0];
            // any order of reads and writes runs back to back
            unique case (st_d.op)
                SFS_READ: begin
                    st_d.drive = 1'b1;
                    // forward a write landing on this same edge
                    // compare indices: the array wraps, so full addresses may differ
                    if (mem_we && (rd_idx == wr_idx)) begin
                        st_d.rdata = wr_merged;
                    end else begin
                        st_d.rdata = mem[rd_idx];
                    end
                end
                SFS_WRITE: begin
                    st_d.drive = 1'b0;
                    st_d.wr_pend = 1'b1;
                    st_d.wr_addr = st_d.addr;
                    st_d.wr_lanes = ~byte_lane_write_n_i;
                end
                SFS_IDLE: begin
                    st_d.drive = 1'b0;
                end
            endcase
        end
        // sleep aborts any operation; a write still owed its data is dropped
        if (st_d.sleep) begin
            st_d.op = SFS_IDLE;
            st_d.drive = 1'b0;
            st_d.wr_pend = 1'b0;
        end
        st_d.low_power = st_d.sleep || (st_d.op == SFS_IDLE);
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q <= '{op: SFS_IDLE, sleep: 1'b0, low_power: 1'b1, default: '0};
        end else begin
            st_q <= st_d;
        end
    end

    assign dq_o = st_q.rdata;
    // output enable acts without the clock on top of internal driver control
    assign dq_oe_o = st_q.drive && !output_enable_n_i;
    assign low_power_o = st_q.low_power;

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    logic load_cmd;
    logic adv_lin;
    assign load_cmd = ce && !load_or_advance_i && sel && !st_q.sleep && !st_d.sleep;
    assign adv_lin = ce && load_or_advance_i && (st_q.op != SFS_IDLE) && !burst_order_i
        && !st_d.sleep;

    sequence s_write_cmd;
        load_cmd && !write_enable_n_i;
    endsequence

    sequence s_read_cmd;
        load_cmd && write_enable_n_i;
    endsequence

    // sleep overrides suspension, so a suspended edge counts only while awake
    sequence s_suspend;
        clock_qualify_n_i && !st_d.sleep;
    endsequence

    sequence s_advance;
        ce && load_or_advance_i && (st_q.op != SFS_IDLE) && !st_d.sleep;
    endsequence

    // four samples: one into the first stage, two to agree, one to act
    sequence s_sleep_held;
        sleep_request_i [*4];
    endsequence

    sequence s_wake_held;
        !sleep_request_i [*4];
    endsequence

    chk_hold_suspend: assert property (
        s_suspend |=> $stable(dq_o) && $stable(st_q.drive)
            && $stable(st_q.addr))
        else $error("state moved on a suspended edge");

    chk_write_no_drive: assert property (
        s_write_cmd |=> !st_q.drive && !dq_oe_o && st_q.wr_pend)
        else $error("drivers on during write data phase");

    chk_read_flow: assert property (
        s_read_cmd |=> st_q.drive && (st_q.op == SFS_READ) && !low_power_o)
        else $error("read data not driven after capture edge");

    chk_wr_then_rd: assert property (
        s_write_cmd ##1 s_read_cmd |=> st_q.drive && !st_q.wr_pend)
        else $error("turnaround from write to read stalled");

    chk_addr_capture: assert property (
        load_cmd |=> st_q.addr == $past(address_i) && st_q.burst_cnt == 2'h0)
        else $error("address not registered on load");

    chk_select_gate: assert property (
        ce && !load_or_advance_i && !sel |=> st_q.op == SFS_IDLE && low_power_o)
        else $error("device acted while deselected");

    chk_oe_async: assert property (
        output_enable_n_i |-> !dq_oe_o)
        else $error("drivers on with output enable off");

    chk_burst_linear: assert property (
        adv_lin |=> st_q.addr[1:0] == $past(st_q.burst_start) + st_q.burst_cnt)
        else $error("linear burst address wrong");

    chk_sleep_power: assert property (
        st_q.sleep |-> low_power_o && !st_q.drive && !st_q.wr_pend)
        else $error("sleep did not reach low power");

    chk_write_commit: assert property (
        s_write_cmd ##1 ce |-> mem_we && wr_idx == $past(address_i[IDX_W-1:0]))
        else $error("write not committed on data edge");

    chk_lane_capture: assert property (
        s_write_cmd
        |=> st_q.wr_lanes == ~$past(byte_lane_write_n_i))
        else $error("lane selects not captured with write");

    chk_adv_idle: assert property (
        ce && load_or_advance_i && (st_q.op == SFS_IDLE)
        |=> (st_q.op == SFS_IDLE) && $stable(st_q.burst_cnt))
        else $error("advance while idle started an operation");

    chk_adv_count: assert property (
        s_advance
        |=> st_q.op == $past(st_q.op) && st_q.burst_cnt == $past(st_q.burst_cnt) + 2'h1)
        else $error("advance did not continue the operation");

    chk_load_start: assert property (
        s_read_cmd
        |=> st_q.burst_start == $past(address_i[1:0]) && st_q.burst_cnt == 2'h0)
        else $error("burst start not loaded");

    // the upper address bits never move inside a burst
    chk_burst_inter: assert property (
        s_advance ##0 burst_order_i
        |=> st_q.addr[1:0] == ($past(st_q.burst_start) ^ st_q.burst_cnt)
            && st_q.addr[`SFS_ADDR_W-1:2] == $past(st_q.addr[`SFS_ADDR_W-1:2]))
        else $error("interleaved burst address wrong");

    chk_rd_then_wr: assert property (
        s_read_cmd ##1 s_write_cmd
        |=> !st_q.drive && st_q.wr_pend && (st_q.op == SFS_WRITE))
        else $error("turnaround from read to write stalled");

    chk_phase_off: assert property (
        st_q.wr_pend
        |-> !st_q.drive && !dq_oe_o)
        else $error("drivers on while write data is owed");

    chk_sleep_enter: assert property (
        s_sleep_held
        |=> st_q.sleep && low_power_o && !st_q.drive)
        else $error("held sleep request not obeyed");

    chk_sleep_exit: assert property (
        s_wake_held
        |=> !st_q.sleep)
        else $error("device stayed asleep after request fell");

    chk_pend_wait: assert property (
        st_q.wr_pend ##0 s_suspend
        |=> st_q.wr_pend && $stable(st_q.wr_addr) && $stable(st_q.wr_lanes))
        else $error("pending write lost on suspended edge");

    chk_drive_read: assert property (
        st_q.drive
        |-> (st_q.op == SFS_READ) && !st_q.sleep)
        else $error("drivers on outside a read");

    chk_suspend_state: assert property (
        s_suspend
        |=> $stable(st_q.op) && $stable(st_q.wr_pend) && $stable(st_q.burst_cnt))
        else $error("operation moved on a suspended edge");

    chk_oe_follow: assert property (
        !output_enable_n_i && st_q.drive
        |-> dq_oe_o)
        else $error("drivers off during a read with output enable on");
endmodule

// *** tb/sfs_ctrl_model.sv ***
// far-side controller model that owns the shared data bus
`timescale 1ns/1ps
module sfs_ctrl_model
    import sfs_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic qual_n_i,
    input wire logic sel_i,
    input wire logic ld_i,
    input wire logic we_n_i,
    input wire sfs_word_t wdata_i,
    input wire sfs_word_t dev_dq_i,
    input wire logic dev_oe_i,
    output sfs_word_t bus_o
);
    logic drv_q;
    sfs_word_t last_q;
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            drv_q <= 1'b0;
            last_q <= 36'h0_0000_0000;
        end else begin
            last_q <= bus_o;
            if (!qual_n_i) begin
                drv_q <= sel_i && !ld_i && !we_n_i;
            end
        end
    end
    // idle bus flips each cycle so a stale word never looks valid
    assign bus_o = (dev_oe_i && drv_q) ? 'x : dev_oe_i ? dev_dq_i : drv_q ? wdata_i : ~last_q;
endmodule

// *** tb/sfs_sram_port_test.sv ***
// self-checking bench of the flow-through sram port
`timescale 1ns/1ps
module sfs_sram_port_test;
    import sfs_pkg::*;
    logic sys_clk_i, rst_n_i, cq_n, sa_n, sb, sc_n, we_n, la, bo, oe_n, slp, oe, lp;
    sfs_lanes_t bw_n;
    sfs_addr_t adr;
    sfs_word_t dq, bus, wd;
    int errors, cmp_count;
    sfs_sram_port #(.MEM_DEPTH(64)) dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
        .clock_qualify_n_i(cq_n), .chip_select_a_n_i(sa_n), .chip_select_b_i(sb),
        .chip_select_c_n_i(sc_n), .write_enable_n_i(we_n), .byte_lane_write_n_i(bw_n),
        .load_or_advance_i(la), .address_i(adr), .burst_order_i(bo),
        .output_enable_n_i(oe_n), .sleep_request_i(slp), .dq_i(bus), .dq_o(dq),
        .dq_oe_o(oe), .low_power_o(lp));
    sfs_ctrl_model ctl (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .qual_n_i(cq_n),
        .sel_i(!sa_n && sb && !sc_n), .ld_i(la), .we_n_i(we_n), .wdata_i(wd),
        .dev_dq_i(dq), .dev_oe_i(oe), .bus_o(bus));
    task chk(input sfs_word_t got, input sfs_word_t exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // pins change after the edge, so the following edge captures them
    task put(input logic l, input logic w, input int a, input sfs_lanes_t b);
        @(posedge sys_clk_i);
        la <= l;
        we_n <= w;
        adr <= sfs_addr_t'(a);
        bw_n <= b;
    endtask
    task t_wr_rd;
        wd = 36'h9_1234_5678;
        put(0, 0, 5, 4'h0);
        put(0, 1, 5, 4'hf);
        #1;
        chk(36'(oe), 36'h0_0000_0000);
        put(0, 1, 9, 4'hf);
        #1;
        chk(dq, 36'h9_1234_5678);
        chk(36'(oe), 36'h0_0000_0001);
        wd = 36'hf_ffff_ffff;
        put(0, 0, 9, 4'h0);
        put(0, 0, 9, 4'ha);
        put(0, 1, 9, 4'hf);
        // full-lane data goes on this edge, the partial write's on the next
        #1;
        wd = 36'h0_0000_0000;
        put(0, 1, 9, 4'hf);
        #1;
        chk(dq, 36'ha_ff00_ff00);
    endtask
    task t_fill;
        for (int i = 0; i < 5; i++) begin
            put(0, i == 4, 16 + i, 4'h0);
            #1;
            wd = 36'(15 + i);
        end
    endtask
    task t_burst(input logic o);
        put(0, 1, 17, 4'hf);
        // order is read on every advance edge, not latched at the load, so it is set before the first advance
        bo <= o;
        for (int k = 0; k < 4; k++) begin
            put(1, 1, 0, 4'hf);
            #1;
            chk(dq, 36'(16 + (o ? (1 ^ k) : ((1 + k) % 4))));
        end
    endtask
    task t_hold;
        put(0, 0, 20, 4'h0);
        wd = 36'h0_0000_0abc;
        @(posedge sys_clk_i);
        cq_n <= 1'b1;
        put(0, 1, 20, 4'hf);
        cq_n <= 1'b0;
        @(posedge sys_clk_i);
        #1;
        chk(dq, 36'h0_0000_0abc);
        put(0, 1, 17, 4'hf);
        @(posedge sys_clk_i);
        cq_n <= 1'b1;
        la <= 1'b1;
        repeat (3) begin
            @(posedge sys_clk_i);
            #1;
            chk(dq, 36'h0_0000_0011);
        end
        cq_n <= 1'b0;
    endtask
    task t_sel;
        for (int s = 0; s < 4; s++) begin
            @(posedge sys_clk_i);
            sa_n <= (s == 0);
            sb <= (s != 1);
            sc_n <= (s == 2);
            la <= 1'b0;
            @(posedge sys_clk_i);
            #1;
            chk(36'(lp), 36'(s < 3));
            chk(36'(oe), 36'(s == 3));
        end
        // a registered gate would still show the old enable here
        @(posedge sys_clk_i);
        oe_n <= 1'b1;
        #1;
        chk(36'(oe), 36'h0_0000_0000);
        oe_n <= 1'b0;
        slp <= 1'b1;
        repeat (6) @(posedge sys_clk_i);
        #1;
        chk(36'(lp), 36'h0_0000_0001);
        slp <= 1'b0;
    endtask
    task t_reset;
        @(posedge sys_clk_i);
        rst_n_i <= 1'b0;
        la <= 1'b1;
        @(posedge sys_clk_i);
        #1;
        chk(dq, 36'h0_0000_0000);
        chk(36'({oe, lp}), 36'h0_0000_0001);
        @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        put(0, 1, 17, 4'hf);
        put(1, 1, 0, 4'hf);
        #1;
        chk(dq, 36'h0_0000_0011);
        chk(36'(oe), 36'h0_0000_0001);
    endtask
    task print_verdict;
        $display("comparisons %0d errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        sys_clk_i = 1'b0;
        forever #10 sys_clk_i = ~sys_clk_i;
    end
    initial begin
        {rst_n_i, cq_n, sa_n, sc_n, we_n, la, bo, oe_n, slp} = 9'h018;
        {sb, bw_n, adr, wd, errors, cmp_count} = '0;
        repeat (20) @(posedge sys_clk_i);
        #1;
        chk(36'(lp), 36'h0_0000_0001);
        rst_n_i <= 1'b1;
        sb <= 1'b1;
        t_wr_rd();
        t_fill();
        t_burst(1'b0);
        t_burst(1'b1);
        t_hold();
        t_sel();
        t_reset();
        print_verdict();
    end
endmodule
